// file: hw/dtm_mem_ctrl.sv
// memory controller end: apb registers, command timing, termination pin
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
module dtm_mem_ctrl import dtm_pkg::*; #(
	parameter int TW = 12
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	dtm_link_if.ctrl         link
);
	// refresh and power-down waits need at least eight bits
	if (TW < 8 || TW > 16)
		$error("timer width out of range");

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_CAL   = 3'b010,
		ST_ISSUE = 3'b100
	} dtm_state_e;

	// ----------------------------------------------------------------
	// registers and apb slave
	// ----------------------------------------------------------------
	logic [31:0] ctrl_reg, ctrl_next, lat_reg, lat_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic [2:0]  cmd_reg, cmd_next;
	logic        bc4_reg, bc4_next, pend_reg, pend_next;
	logic        lvl_reg, lvl_next, fb_reg, fb_next;
	logic        term_reg, term_next, strobe_reg, strobe_next;
	logic        rise_reg, rise_next, valid_reg, valid_next;
	logic        cs_reg, cs_next;
	dtm_state_e  st_reg, st_next;

	logic [5:0] cas_write_latency, al, wr, wl;
	logic [3:0] pl;
	logic [9:0] rfc_base;
	logic [1:0] bin;
	logic       dll_off, chop_fix, parity, pre2, term_force;
	logic       mapped, acc_edge;

	assign dll_off    = ctrl_reg[CTRL_DLL_OFF];
	assign chop_fix   = ctrl_reg[CTRL_CHOP_FIX];
	assign parity     = ctrl_reg[CTRL_PARITY];
	assign pre2       = ctrl_reg[CTRL_PRE2];
	assign term_force = ctrl_reg[CTRL_TERM];
	assign bin        = ctrl_reg[CTRL_BIN_LO +: 2];
	assign cas_write_latency        = lat_reg[LAT_CWL_LO +: 6];
	assign al         = lat_reg[LAT_AL_LO +: 6];
	assign pl         = lat_reg[LAT_PL_LO +: 4];
	assign wr         = lat_reg[LAT_WR_LO +: 6];
	assign rfc_base   = lat_reg[LAT_RFC_LO +: 10];
	assign wl         = 6'(cas_write_latency + al + 6'(pl));

	assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_LAT) ||
		(paddr == OFS_CMD) || (paddr == OFS_STATUS);
	// write lands only at the edge where pready is seen high
	assign acc_edge = psel && penable && pready_reg;

	always_comb begin
		pready_next  = psel && penable && !pready_reg;
		pslverr_next = psel && penable && !pready_reg && !mapped;
		prdata_next  = prdata_reg;
		if (psel && penable && !pready_reg) begin
			case (paddr)
				OFS_CTRL:   prdata_next = ctrl_reg;
				OFS_LAT:    prdata_next = lat_reg;
				OFS_STATUS: prdata_next = {26'h0, ctrl_reg[CTRL_GEAR],
					fb_reg, strobe_reg, lvl_reg, term_reg, pend_reg};
				default:    prdata_next = 32'h0000_0000;
			endcase
		end
		ctrl_next = ctrl_reg;
		lat_next  = lat_reg;
		if (acc_edge && pwrite && paddr == OFS_CTRL)
			ctrl_next = pwdata;
		if (acc_edge && pwrite && paddr == OFS_LAT)
			lat_next = pwdata;
	end

	// ----------------------------------------------------------------
	// timers
	// ----------------------------------------------------------------
	logic          pd_zero, rfc_zero, hi_zero, en_zero, rise_zero, cal_zero;
	logic          pd_load, rfc_load, hi_load, lvl_load, cal_load;
	logic [TW-1:0] pd_val, rfc_val, hi_val, cal_val;
	logic          issue_now;
	logic          is_full_write;

	assign issue_now = (st_reg == ST_ISSUE);
	assign is_full_write = (cmd_reg == CMD_WRITE || cmd_reg == CMD_WRITE_AP)
		&& !bc4_reg && !chop_fix;

	always_comb begin
		pd_load  = issue_now && cmd_reg == CMD_WRITE_AP;
		pd_val   = TW'(wl) + TW'(wr) + TW'(WAP_TAIL) +
			(chop_fix ? TW'(WAP_CHOP_EXTRA) : TW'(WAP_FULL_EXTRA));
		rfc_load = issue_now && cmd_reg == CMD_REFRESH;
		// parity with dll off stretches refresh
		rfc_val  = TW'(rfc_base) + ((parity && dll_off) ? TW'(pl) : '0);
		lvl_load = issue_now && cmd_reg == CMD_LVL_ENTER;
		cal_load = (st_reg == ST_IDLE) && pend_reg;
		cal_val  = TW'(CAL_CLK - 1);
		hi_load  = (term_next && !term_reg) ||
			(issue_now && is_full_write);
		// bins below 1600 share the 1600 code
		if (is_full_write && issue_now)
			hi_val = (pre2 && bin == BIN_2400) ?
				TW'(TERM_HI8_PRE2) : TW'(TERM_HI8);
		else
			// no write or chop four minimum
			hi_val = (pre2 && bin == BIN_2400) ?
				TW'(TERM_HI4_PRE2) : TW'(TERM_HI4);
	end

	dtm_down_timer #(.W(TW)) u_pd (.ref_clk(ref_clk), .rst(rst),
		.load(pd_load), .load_val(pd_val), .zero(pd_zero));
	dtm_down_timer #(.W(TW)) u_rfc (.ref_clk(ref_clk), .rst(rst),
		.load(rfc_load), .load_val(rfc_val), .zero(rfc_zero));
	dtm_down_timer #(.W(TW)) u_hi (.ref_clk(ref_clk), .rst(rst),
		.load(hi_load), .load_val(hi_val - TW'(1)), .zero(hi_zero));
	dtm_down_timer #(.W(TW)) u_en (.ref_clk(ref_clk), .rst(rst),
		.load(lvl_load), .load_val(TW'(LVL_STROBE_EN_CLK)),
		.zero(en_zero));
	dtm_down_timer #(.W(TW)) u_rise (.ref_clk(ref_clk), .rst(rst),
		.load(lvl_load), .load_val(TW'(LVL_FIRST_RISE_CLK)),
		.zero(rise_zero));
	dtm_down_timer #(.W(TW)) u_cal (.ref_clk(ref_clk), .rst(rst),
		.load(cal_load), .load_val(cal_val), .zero(cal_zero));

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	logic may_go;

	// command held until its counter drains
	always_comb begin
		case (cmd_reg)
			CMD_PD_ENTER: may_go = pd_zero && rfc_zero;
			CMD_STROBE:   may_go = lvl_reg && rise_zero;
			default:      may_go = rfc_zero;
		endcase
	end

	always_comb begin
		st_next    = st_reg;
		cmd_next   = cmd_reg;
		bc4_next   = bc4_reg;
		pend_next  = pend_reg;
		valid_next = 1'b0;
		cs_next    = 1'b0;
		rise_next  = 1'b0;
		lvl_next   = lvl_reg;
		// a new order is ignored while one is pending
		if (acc_edge && pwrite && paddr == OFS_CMD && !pend_reg) begin
			cmd_next  = pwdata[2:0];
			bc4_next  = pwdata[3];
			pend_next = pwdata[2:0] != CMD_NOP;
		end
		case (st_reg)
			ST_IDLE: begin
				if (pend_reg && cmd_reg == CMD_STROBE && may_go) begin
					rise_next = 1'b1;
					pend_next = 1'b0;
				end else if (pend_reg && cmd_reg != CMD_STROBE && may_go) begin
					// select leads command by cal clocks
					st_next = ST_CAL;
					cs_next = 1'b1;
				end
			end
			ST_CAL: begin
				cs_next = 1'b1;
				if (cal_zero) begin
					st_next    = ST_ISSUE;
					valid_next = 1'b1;
				end
			end
			ST_ISSUE: begin
				st_next   = ST_IDLE;
				pend_next = 1'b0;
				if (cmd_reg == CMD_LVL_ENTER)
					lvl_next = 1'b1;
				if (cmd_reg == CMD_LVL_EXIT)
					lvl_next = 1'b0;
			end
			default: st_next = ST_IDLE;
		endcase
		strobe_next = lvl_next && (strobe_reg || en_zero) &&
			!(issue_now && cmd_reg == CMD_LVL_ENTER);
		term_next = term_force || (valid_next && (cmd_reg == CMD_WRITE ||
			cmd_reg == CMD_WRITE_AP)) || (term_reg && !hi_zero);
		fb_next = link.lvl_fb_oe ? link.lvl_fb : fb_reg;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg    <= CTRL_RESET;
			lat_reg     <= LAT_RESET;
			prdata_reg  <= 32'h0000_0000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			st_reg      <= ST_IDLE;
			cmd_reg     <= CMD_NOP;
			bc4_reg     <= 1'b0;
			pend_reg    <= 1'b0;
			valid_reg   <= 1'b0;
			cs_reg      <= 1'b0;
			rise_reg    <= 1'b0;
			lvl_reg     <= 1'b0;
			strobe_reg  <= 1'b0;
			term_reg    <= 1'b0;
			fb_reg      <= 1'b0;
		end else begin
			ctrl_reg    <= ctrl_next;
			lat_reg     <= lat_next;
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			st_reg      <= st_next;
			cmd_reg     <= cmd_next;
			bc4_reg     <= bc4_next;
			pend_reg    <= pend_next;
			valid_reg   <= valid_next;
			cs_reg      <= cs_next;
			rise_reg    <= rise_next;
			lvl_reg     <= lvl_next;
			strobe_reg  <= strobe_next;
			term_reg    <= term_next;
			fb_reg      <= fb_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata              = prdata_reg;
	assign pready              = pready_reg;
	assign pslverr             = pslverr_reg;
	assign link.cmd_valid      = valid_reg;
	assign link.cmd_type       = cmd_reg;
	assign link.cmd_bc4        = bc4_reg;
	assign link.cs_act         = cs_reg;
	assign link.term_pin       = term_reg;
	assign link.strobe_drive   = strobe_reg;
	assign link.strobe_rise    = rise_reg;
	assign link.cfg_wl         = wl;
	assign link.cfg_chop_fixed = chop_fix;
	assign link.cfg_dll_off    = dll_off;
	// gear-down never enabled at these bins
	assign link.cfg_gear_en    = 1'b0;
	assign link.cfg_bin        = bin;
endmodule

// file: hw/dtm_pkg.sv
// shared constants, command codes and helpers of the timing pair
// What this block does
// - wait wl+2+wr+1 after chop-fixed autoprecharge write
// - termination follows pin after write latency minus two
// - dll off: termination switches one to nine ns; the device model follows the pin one clock (10 ns) later
// - burst-eight write: term pin high six/seven
// - no write or chop four: high four/five
// - forty clocks before first leveling strobe rise
// - twenty-five clocks before driving leveling strobe
// - leveling feedback within 9.5 ns of rise; the device model shows the sampled level one clock (10 ns) after rise
// - gear-down refused at every supported bin
// - internal write starts wl+4, chop-fixed wl+2
// - parity with dll off adds parity latency
// - select-to-command latency max(3, 3.748 ns)
// - nanoseconds become clocks by rounding to nearest; maximum times round down, never below one
// - below 1600 use the 1600 table
package dtm_pkg;

	// ----------------------------------------------------------------
	// clock and times
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS      = 10000;
	localparam int CAL_TIME_PS        = 3748;
	localparam int CAL_MIN_CLK        = 3;
	localparam int ASYNC_TERM_MAX_PS  = 9000;
	localparam int LVL_OUT_MAX_PS     = 9500;
	localparam int LVL_FIRST_RISE_CLK = 40;
	localparam int LVL_STROBE_EN_CLK  = 25;
	localparam int WAP_CHOP_EXTRA     = 2;
	localparam int WAP_FULL_EXTRA     = 4;
	localparam int WAP_TAIL           = 1;
	localparam int TERM_LAT_SUB       = 2;
	localparam int IWR_FULL_DELAY     = 4;
	localparam int IWR_CHOP_DELAY     = 2;

	// ----------------------------------------------------------------
	// speed bins and termination high times
	// ----------------------------------------------------------------
	localparam logic [1:0] BIN_1600 = 2'h0;
	localparam logic [1:0] BIN_2400 = 2'h3;
	localparam int TERM_HI8      = 6;
	localparam int TERM_HI8_PRE2 = 7;
	localparam int TERM_HI4      = 4;
	localparam int TERM_HI4_PRE2 = 5;

	// ----------------------------------------------------------------
	// register offsets, fields, reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_LAT    = 8'h04;
	localparam logic [7:0] OFS_CMD    = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam int CTRL_DLL_OFF  = 0;
	localparam int CTRL_CHOP_FIX = 1;
	localparam int CTRL_PARITY   = 2;
	localparam int CTRL_PRE2     = 3;
	localparam int CTRL_GEAR     = 4;
	localparam int CTRL_TERM     = 5;
	localparam int CTRL_BIN_LO   = 6;
	localparam int LAT_CWL_LO    = 0;
	localparam int LAT_AL_LO     = 6;
	localparam int LAT_PL_LO     = 12;
	localparam int LAT_WR_LO     = 16;
	localparam int LAT_RFC_LO    = 22;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] LAT_RESET  = 32'h0c80_0289;

	typedef enum logic [2:0] {
		CMD_WRITE     = 3'h0,
		CMD_WRITE_AP  = 3'h1,
		CMD_REFRESH   = 3'h2,
		CMD_PD_ENTER  = 3'h3,
		CMD_LVL_ENTER = 3'h4,
		CMD_LVL_EXIT  = 3'h5,
		CMD_STROBE    = 3'h6,
		CMD_NOP       = 3'h7
	} dtm_cmd_e;

	function automatic int ns_to_clk(input int ps);
		int c;
		c = (ps + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int max2(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	localparam int CAL_CLK = max2(CAL_MIN_CLK, ns_to_clk(CAL_TIME_PS));
	// longest time rounds down, never below one
	localparam int ASYNC_TERM_CLK = max2(1, ASYNC_TERM_MAX_PS / CLK_PERIOD_PS);
	localparam int LVL_OUT_CLK = max2(1, LVL_OUT_MAX_PS / CLK_PERIOD_PS);

endpackage

// file: hw/dtm_link_if.sv
// link between the timing controller and the memory device model
interface dtm_link_if;
	logic       cmd_valid;
	logic [2:0] cmd_type;
	logic       cmd_bc4;
	logic       cs_act;
	logic       term_pin;
	logic       strobe_drive;
	logic       strobe_rise;
	logic [5:0] cfg_wl;
	logic       cfg_chop_fixed;
	logic       cfg_dll_off;
	logic       cfg_gear_en;
	logic [1:0] cfg_bin;
	logic       lvl_fb;
	logic       lvl_fb_oe;

	modport ctrl (
		output cmd_valid, cmd_type, cmd_bc4, cs_act, term_pin,
		output strobe_drive, strobe_rise,
		output cfg_wl, cfg_chop_fixed, cfg_dll_off, cfg_gear_en, cfg_bin,
		input  lvl_fb, lvl_fb_oe
	);
	modport dev (
		input  cmd_valid, cmd_type, cmd_bc4, cs_act, term_pin,
		input  strobe_drive, strobe_rise,
		input  cfg_wl, cfg_chop_fixed, cfg_dll_off, cfg_gear_en, cfg_bin,
		output lvl_fb, lvl_fb_oe
	);
endinterface

// file: hw/dtm_down_timer.sv
// loadable down-counter holding one cycle constraint
module dtm_down_timer import dtm_pkg::*; #(
	parameter int W = 12
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              zero
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	// narrower counters cannot hold the shortest wait
	if (W < 4)
		$error("timer too narrow");

	// keep the longer of old and new wait
	always_comb begin
		count_next = count_reg;
		if (count_reg != '0)
			count_next = count_reg - W'(1);
		if (load && load_val > count_next)
			count_next = load_val;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end

	assign zero = (count_reg == '0);
endmodule

// file: hw/dtm_mem_dev.sv
// memory device end: termination latency, leveling feedback, write start
module dtm_mem_dev import dtm_pkg::*; #(
	parameter int HIST = 68
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic clk_level,
	output logic      term_active,
	output logic      wr_start,
	output logic      gear_refused,
	dtm_link_if.dev   link
);
	// largest write latency plus write start must fit the history
	if (HIST < 64 + IWR_FULL_DELAY)
		$error("history too short");

	logic [HIST-1:0] pin_hist_reg, pin_hist_next;
	logic [HIST-1:0] wr_hist_reg, wr_hist_next;
	logic            term_reg, term_next, start_reg, start_next;
	logic            fb_reg, fb_next, fb_oe_reg, fb_oe_next;
	logic            gear_reg, gear_next;
	logic            is_wr;
	int              t_idx, w_idx;

	assign is_wr = link.cmd_valid && (link.cmd_type == CMD_WRITE ||
		link.cmd_type == CMD_WRITE_AP);

	always_comb begin
		pin_hist_next = {pin_hist_reg[HIST-2:0], link.term_pin};
		wr_hist_next  = {wr_hist_reg[HIST-2:0], is_wr};
		// hist[0] and the output flop each add one edge
		t_idx = int'(link.cfg_wl) - TERM_LAT_SUB - 2;
		if (t_idx < 0)
			t_idx = 0;
		// chop fixed starts two after wl, else four
		w_idx = int'(link.cfg_wl) - 2 +
			(link.cfg_chop_fixed ? IWR_CHOP_DELAY : IWR_FULL_DELAY);
		if (w_idx < 0)
			w_idx = 0;
		if (link.cfg_dll_off)
			term_next = link.term_pin;
		else
			// on and off both at wl minus two
			term_next = pin_hist_reg[t_idx];
		start_next = wr_hist_reg[w_idx];
		// sampled level one clock after strobe rise
		fb_oe_next = link.strobe_drive;
		fb_next    = link.strobe_rise ? clk_level : fb_reg;
		gear_next  = link.cfg_gear_en;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_hist_reg <= '0;
			wr_hist_reg  <= '0;
			term_reg     <= 1'b0;
			start_reg    <= 1'b0;
			fb_reg       <= 1'b0;
			fb_oe_reg    <= 1'b0;
			gear_reg     <= 1'b0;
		end else begin
			pin_hist_reg <= pin_hist_next;
			wr_hist_reg  <= wr_hist_next;
			term_reg     <= term_next;
			start_reg    <= start_next;
			fb_reg       <= fb_next;
			fb_oe_reg    <= fb_oe_next;
			gear_reg     <= gear_next;
		end
	end

	assign term_active    = term_reg;
	assign wr_start       = start_reg;
	assign gear_refused   = gear_reg;
	assign link.lvl_fb    = fb_reg;
	assign link.lvl_fb_oe = fb_oe_reg;
endmodule

// file: sim/dtm_link_monitor.sv
// checker of the link between the controller end and the device end
module dtm_link_monitor import dtm_pkg::*; (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       cmd_valid,
	input wire logic [2:0] cmd_type,
	input wire logic       cmd_bc4,
	input wire logic       cs_act,
	input wire logic       term_pin,
	input wire logic       strobe_drive,
	input wire logic       strobe_rise,
	input wire logic [5:0] cfg_wl,
	input wire logic       cfg_chop_fixed,
	input wire logic       cfg_gear_en,
	input wire logic       lvl_fb_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------
	// cycle counters
	// ------
	logic [7:0] hi_reg, hi_next, lvl_reg, lvl_next, wap_reg, wap_next;
	logic       b8_reg, b8_next;
	logic       wr_cmd;

	// counters saturate so a long idle never wraps into a false short gap
	always_comb begin
		wr_cmd = cmd_valid && (cmd_type == CMD_WRITE ||
			cmd_type == CMD_WRITE_AP);
		hi_next = term_pin ? hi_reg + {7'h0, hi_reg != 8'hff} : 8'h00;
		b8_next = term_pin && (b8_reg || (wr_cmd && !cmd_bc4 && !cfg_chop_fixed));
		lvl_next = lvl_reg + {7'h0, lvl_reg != 8'h00 && lvl_reg != 8'hff};
		if (cmd_valid && cmd_type == CMD_LVL_ENTER) begin
			lvl_next = 8'h01;
		end
		wap_next = wap_reg + {7'h0, wap_reg != 8'h00 && wap_reg != 8'hff};
		if (cmd_valid && cmd_type == CMD_WRITE_AP) begin
			wap_next = 8'h01;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hi_reg <= 8'h00;
			lvl_reg <= 8'h00;
			wap_reg <= 8'h00;
			b8_reg <= 1'b0;
		end else begin
			hi_reg <= hi_next;
			lvl_reg <= lvl_next;
			wap_reg <= wap_next;
			b8_reg <= b8_next;
		end
	end

	// ------
	// properties
	// ------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	cs_phase_a: assert property (
		$rose(cs_act) |-> cs_act[*3] ##1 cmd_valid)
		else $error("select phase");
	cmd_cs_a: assert property (
		cmd_valid && cmd_type != CMD_STROBE |-> $past(cs_act))
		else $error("command without select");
	gear_off_a: assert property (
		!cfg_gear_en) else $error("gear enabled");
	hold_min_a: assert property (
		!term_pin && hi_reg != 8'h00 |-> hi_reg >= 8'd4)
		else $error("term high too short");
	hold_burst_a: assert property (
		!term_pin && hi_reg != 8'h00 && b8_reg |-> hi_reg >= 8'd6)
		else $error("term high too short after burst");
	first_rise_a: assert property (
		strobe_rise |-> lvl_reg >= 8'd40) else $error("strobe rise early");
	strobe_en_a: assert property (
		$rose(strobe_drive) |-> lvl_reg >= 8'd25)
		else $error("strobe drive early");
	fb_on_a: assert property (
		$rose(strobe_drive) |=> lvl_fb_oe) else $error("feedback not driven");
	fb_off_a: assert property (
		$fell(strobe_drive) |=> !lvl_fb_oe)
		else $error("feedback not released");
	pd_wait_a: assert property (
		cmd_valid && cmd_type == CMD_PD_ENTER && wap_reg != 8'h00
		|-> wap_reg >= cfg_wl + (cfg_chop_fixed ? 8'd3 : 8'd5))
		else $error("power-down too early");
endmodule

// file: sim/tb_top.sv
// self-checking bench for the controller and device pair
module tb_top import dtm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int CAS_LAT = 9;
	localparam int ADD_LAT = 2;
	localparam int PAR_LAT = 1;
	localparam int REC_TIME = 3;
	localparam int REF_TIME = 20;
	localparam int W_LAT = CAS_LAT + ADD_LAT + PAR_LAT;
	localparam logic [31:0] LAT_VAL = (32'(REF_TIME) << LAT_RFC_LO)
		| (32'(REC_TIME) << LAT_WR_LO) | (32'(PAR_LAT) << LAT_PL_LO)
		| (32'(ADD_LAT) << LAT_AL_LO) | 32'(CAS_LAT);
	// ctrl, order, chop, term latency, write start, term high
	localparam int MD [4][6] = '{
		'{'h00, 0, 0, W_LAT - 2, W_LAT + 4, TERM_HI8},
		'{'h00, 0, 1, W_LAT - 2, W_LAT + 4, TERM_HI4},
		'{'hc8, 0, 0, W_LAT - 2, W_LAT + 4, TERM_HI8_PRE2},
		'{'h03, 1, 0, 1, W_LAT + 2, TERM_HI4}};

	logic        ref_clk, rst, psel, penable, pwrite, clk_level;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rq;
	logic        pready, pslverr, re, fb_at;
	logic        term_active, wr_start, gear_refused;
	logic [4:0]  pv;
	int          mismatches, check_count, cyc, t_cs, t_ton, t_toff, t_wr, t_sd;
	int          t_sr, t0, t_aoff;
	int          t_ty [8];

	dtm_link_if link ();
	dtm_mem_ctrl dtm_mem_ctrl_i (.ref_clk(ref_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	dtm_mem_dev dtm_mem_dev_i (.ref_clk(ref_clk), .rst(rst),
		.clk_level(clk_level), .term_active(term_active), .wr_start(wr_start),
		.gear_refused(gear_refused), .link(link));
	dtm_link_monitor dtm_link_monitor_i (.ref_clk(ref_clk), .rst(rst),
		.cmd_valid(link.cmd_valid), .cmd_type(link.cmd_type),
		.cmd_bc4(link.cmd_bc4), .cs_act(link.cs_act), .term_pin(link.term_pin),
		.strobe_drive(link.strobe_drive), .strobe_rise(link.strobe_rise),
		.cfg_wl(link.cfg_wl), .cfg_chop_fixed(link.cfg_chop_fixed),
		.cfg_gear_en(link.cfg_gear_en), .lvl_fb_oe(link.lvl_fb_oe));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ------
	// edge time stamps of link events
	// ------
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (link.cmd_valid === 1'b1) t_ty[link.cmd_type] = cyc;
		if (link.cs_act && !pv[0]) t_cs = cyc;
		if (term_active && !pv[1]) t_ton = cyc;
		if (!term_active && pv[1]) t_aoff = cyc;
		if (!link.term_pin && pv[2]) t_toff = cyc;
		if (link.strobe_drive && !pv[3]) t_sd = cyc;
		if (link.strobe_rise) t_sr = cyc;
		if (wr_start) t_wr = cyc;
		if (pv[4]) fb_at = link.lvl_fb;
		pv = {link.strobe_rise, link.strobe_drive, link.term_pin, term_active,
			link.cs_act};
	end

	// ------
	// tasks
	// ------
	task automatic check(input string what, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic hang;
		mismatches++;
		$display("[FAIL] wait expected done seen none");
		wrap_up;
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			n++;
		end
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) hang;
	endtask

	// order is done once pending clears; a refused order returns when the earlier pending order clears
	task automatic cmd(input dtm_cmd_e c, input logic b);
		int n;
		n = 0;
		apb(1'b1, OFS_CMD, {28'h0, b, c});
		rq = 32'h1;
		while (rq[0] !== 1'b0 && n < 400) begin
			apb(1'b0, OFS_STATUS, 32'h0);
			n++;
		end
		if (n >= 400) hang;
	endtask

	// ------
	// main sequence
	// ------
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		clk_level = 1'b1;
		{mismatches, check_count, cyc} = '0;
		pv = '0;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, OFS_CTRL, 32'h0);
		check("ctrl reset", rq, CTRL_RESET);
		check("mapped error", re, 0);
		apb(1'b0, OFS_LAT, 32'h0);
		check("lat reset", rq, LAT_RESET);
		apb(1'b0, 8'h10, 32'h0);
		check("unmapped error", re, 1);
		check("unmapped data", rq, 0);
		apb(1'b1, OFS_LAT, LAT_VAL);
		apb(1'b0, OFS_LAT, 32'h0);
		check("lat", rq, LAT_VAL);
		check("write latency", link.cfg_wl, W_LAT);
		apb(1'b1, OFS_CTRL, 32'h10);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("gear cfg", link.cfg_gear_en, 0);
		check("gear refused", gear_refused, 0);
		check("gear request", rq[5], 1);
		apb(1'b1, OFS_CTRL, 32'h20);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("term force", rq[1], 1);
		apb(1'b1, OFS_CTRL, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFS_CTRL, {29'h0, i > 0, 1'b0, i == 2});
			cmd(CMD_REFRESH, 1'b0);
			cmd(CMD_WRITE, 1'b0);
			t_sd = t_ty[CMD_WRITE] - t_ty[CMD_REFRESH];
			if (i == 0) t0 = t_sd;
			if (i == 0) check("refresh gap", t_sd >= REF_TIME, 1);
			if (i == 1) check("parity only", t_sd, t0);
			if (i == 2) check("parity dll off", t_sd, t0 + PAR_LAT);
		end
		$display("test refresh done");
		apb(1'b1, OFS_CTRL, 32'h0);
		cmd(CMD_LVL_ENTER, 1'b0);
		for (int i = 0; i < 2; i++) begin
			clk_level <= (i == 0);
			// an exit written while the strobe still waits is ignored
			if (i == 0) apb(1'b1, OFS_CMD, {29'h0, CMD_STROBE});
			cmd((i == 0) ? CMD_LVL_EXIT : CMD_STROBE, 1'b0);
			if (i == 0) check("order refused", rq[2], 1);
			repeat (2) @(posedge ref_clk);
			check("feedback", fb_at, i == 0);
			t0 = t_sr - t_ty[CMD_LVL_ENTER];
			if (i == 0) check("first rise", t0 >= 40, 1);
		end
		check("strobe drive", t_sd - t_ty[CMD_LVL_ENTER] >= 25, 1);
		cmd(CMD_LVL_EXIT, 1'b0);
		check("feedback release", link.lvl_fb_oe, 0);
		$display("test leveling done");
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, OFS_CTRL, 32'(MD[m][0]));
			cmd(dtm_cmd_e'(MD[m][1]), MD[m][2] != 0);
			t0 = t_ty[MD[m][1]];
			check("select to command", t0 - t_cs, CAL_CLK);
			if (m == 3) cmd(CMD_PD_ENTER, 1'b0);
			repeat (W_LAT + 8) @(posedge ref_clk);
			check("term on lat", t_ton - t0, MD[m][3]);
			check("term off lat", t_aoff - t_toff, MD[m][3]);
			check("write start", t_wr - t0, MD[m][4]);
			check("term high", t_toff - t0 >= MD[m][5], 1);
			if (m == 3) check("powerdown wait",
				t_ty[CMD_PD_ENTER] - t0 >= W_LAT + 3 + REC_TIME, 1);
		end
		$display("test writes done");
		wrap_up;
	end
endmodule
